// ===== hw/mvd_pkg.sv
// Constants shared by the magnetic vehicle detector: register map, reset values, field limits.
package mvd_pkg;

  // Register addresses as seen by the register-access host.
  localparam logic [15:0] ADDR_BASELINE_CAPTURE = 16'h1195;
  localparam logic [15:0] ADDR_AXIS_DISABLE_MASK = 16'h1196;
  localparam logic [15:0] ADDR_COMP_MEDIAN_BYPASS = 16'h1197;
  localparam logic [15:0] ADDR_SENSE_MEDIAN_BYPASS = 16'h1198;
  localparam logic [15:0] ADDR_LOWPASS_STRENGTH = 16'h1199;
  localparam logic [15:0] ADDR_ON_DEBOUNCE_COUNT = 16'h119a;
  localparam logic [15:0] ADDR_OFF_DEBOUNCE_COUNT = 16'h119b;
  localparam logic [15:0] ADDR_CHANGE_RATE_FILTER = 16'h119d;
  localparam logic [15:0] ADDR_DETECT_THRESHOLD = 16'h119e;
  localparam logic [15:0] ADDR_DETECT_HYSTERESIS = 16'h119f;
  localparam logic [15:0] ADDR_DRIFT_TIME = 16'h11a0;
  localparam logic [15:0] ADDR_DRIFT_THRESHOLD = 16'h11a1;
  localparam logic [15:0] ADDR_DRIFT_TAU = 16'h11a2;
  localparam logic [15:0] ADDR_DEVIATION_TOTAL = 16'h11a9;
  localparam logic [15:0] ADDR_DEVIATION_X = 16'h11aa;
  localparam logic [15:0] ADDR_DEVIATION_Y = 16'h11ab;
  localparam logic [15:0] ADDR_DEVIATION_Z = 16'h11ac;
  localparam logic [15:0] ADDR_AMBIENT_X = 16'h11ad;
  localparam logic [15:0] ADDR_AMBIENT_Y = 16'h11ae;
  localparam logic [15:0] ADDR_AMBIENT_Z = 16'h11af;
  localparam logic [15:0] ADDR_RAW_FIELD_X = 16'h11b0;
  localparam logic [15:0] ADDR_RAW_FIELD_Y = 16'h11b1;
  localparam logic [15:0] ADDR_RAW_FIELD_Z = 16'h11b2;

  // Values after reset (factory defaults).
  localparam logic [15:0] RESET_ZERO = 16'h0000;
  localparam logic [15:0] RESET_DETECT_THRESHOLD = 16'h0096;
  localparam logic [15:0] RESET_DETECT_HYSTERESIS = 16'h001e;

  // Value that triggers a baseline capture.
  localparam logic [15:0] CAPTURE_COMMAND = 16'h0001;

  // Axis bit positions in the disable mask.
  localparam int AXIS_X_BIT = 0;
  localparam int AXIS_Y_BIT = 1;
  localparam int AXIS_Z_BIT = 2;
  localparam int AXIS_COUNT = 3;

  // Low-pass tau levels: level 0 is the weakest, level 6 the strongest.
  localparam logic [2:0] TAU_WEAKEST_LEVEL = 3'h0;
  localparam logic [2:0] TAU_STRONGEST_LEVEL = 3'h6;

  // Largest shift used by the drift tracking filter.
  localparam logic [3:0] DRIFT_TAU_MAX = 4'hf;

  // Largest debounce count.
  localparam logic [7:0] DEBOUNCE_MAX = 8'hff;

endpackage

// ===== hw/mvd_detector.sv
// Magnetic vehicle detector: baseline, filters, deviation, debounce, hysteresis and drift.
// What this block does
// - Writing one captures all axes as baseline.
// - Deviation from baseline reported as growing magnitude.
// - Mask bits 0,1,2 disable x,y,z axes.
// - Writing one bypasses compensation median filter.
// - Writing one bypasses sensing median filter.
// - Low-pass strength 0 weakest to 6 strongest.
// - On needs 1-255 samples above; 0 disables.
// - Off needs 1-255 samples low; 0 disables.
// - Result bit sets above threshold, clears below off-point.
// - Threshold resets to 150, hysteresis to 30.
// - Threshold and hysteresis take full 16 bits.
// - Drift filter nudges baseline toward quiet ambient.
// - Per-axis baseline difference readable, read-only.
// - Total deviation combines x, y, z differences.
// - Per-axis stored baseline readable, read-only.
// - Per-axis raw field readable, read-only.
`timescale 1ns/1ns

module mvd_detector (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Sensing element samples, two's complement, valid with sample_tick.
  input wire logic sample_tick,
  input wire logic signed [15:0] field_x,
  input wire logic signed [15:0] field_y,
  input wire logic signed [15:0] field_z,
  // Register access from the host.
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_addr_err,
  // Detection results.
  output logic detect_state,
  output logic [15:0] detect_result,
  output logic baseline_valid
);

  // All state of the block in one record.
  typedef struct packed {
    logic [15:0] cap;
    logic [15:0] dis;
    logic [15:0] cmed;
    logic [15:0] smed;
    logic [15:0] lp;
    logic [15:0] onc;
    logic [15:0] offc;
    logic [15:0] delta;
    logic [15:0] thr;
    logic [15:0] hys;
    logic [15:0] dtime;
    logic [15:0] dthr;
    logic [15:0] dtau;
    logic [2:0][15:0] raw;
    logic [2:0][15:0] hist;
    logic [2:0][15:0] filt;
    logic [2:0][15:0] base;
    logic [2:0][15:0] dev;
    logic [15:0] total;
    logic base_valid;
    logic state;
    logic [7:0] on_cnt;
    logic [7:0] off_cnt;
    logic [15:0] drift_cnt;
    logic [15:0] rd_data;
    logic rd_valid;
    logic addr_err;
    logic [15:0] result;
  } mvd_state_t;

  mvd_state_t q;
  mvd_state_t next_q;

  // Median of three signed samples.
  function automatic logic [15:0] mvd_med3(input logic [15:0] a, input logic [15:0] b,
                                           input logic [15:0] c);
    logic signed [15:0] sa;
    logic signed [15:0] sb;
    logic signed [15:0] sc;
    sa = a;
    sb = b;
    sc = c;
    if ((sa >= sb && sa <= sc) || (sa <= sb && sa >= sc)) begin
      return a;
    end else if ((sb >= sa && sb <= sc) || (sb <= sa && sb >= sc)) begin
      return b;
    end else begin
      return c;
    end
  endfunction

  // Magnitude of the difference of two signed values; it always fits 16 unsigned bits.
  function automatic logic [15:0] mvd_absdiff(input logic [15:0] a, input logic [15:0] b);
    logic signed [16:0] d;
    d = $signed({a[15], a}) - $signed({b[15], b});
    if (d < 0) begin
      d = -d;
    end
    return d[15:0];
  endfunction

  // Difference of two signed values at 17 bits.
  function automatic logic signed [16:0] mvd_sdiff(input logic [15:0] a, input logic [15:0] b);
    return $signed({a[15], a}) - $signed({b[15], b});
  endfunction

  // Debounce count limited to 255; larger writes act as the maximum.
  function automatic logic [7:0] mvd_count_limit(input logic [15:0] v);
    if (|v[15:8]) begin
      return mvd_pkg::DEBOUNCE_MAX;
    end
    return v[7:0];
  endfunction

  // Outputs are fields of the registered record.
  assign reg_rdata = q.rd_data;
  assign reg_rvalid = q.rd_valid;
  assign reg_addr_err = q.addr_err;
  assign detect_state = q.state;
  assign detect_result = q.result;
  assign baseline_valid = q.base_valid;

  // Next-state logic: sample processing first, host writes afterwards so they win.
  always_comb begin
    logic [2:0][15:0] samp;
    logic [2:0][15:0] comp_val;
    logic [15:0] sense_val;
    logic [15:0] med;
    logic [2:0] tau;
    logic [3:0] dtau;
    logic signed [16:0] diff;
    logic signed [16:0] step;
    logic signed [16:0] acc;
    logic [17:0] sum;
    logic [15:0] total;
    logic above;
    logic below;
    logic [7:0] on_lim;
    logic [7:0] off_lim;
    logic [15:0] drift_next;
    samp = '0;
    comp_val = '0;
    sense_val = '0;
    med = '0;
    tau = '0;
    dtau = '0;
    diff = '0;
    step = '0;
    acc = '0;
    sum = '0;
    total = '0;
    above = 1'b0;
    below = 1'b0;
    on_lim = mvd_count_limit(q.onc);
    off_lim = mvd_count_limit(q.offc);
    drift_next = '0;
    next_q = q;
    // Read strobe and error flag are single-cycle pulses.
    next_q.rd_valid = 1'b0;
    next_q.addr_err = 1'b0;

    // Strength above the strongest level is treated as the strongest.
    if (q.lp > 16'(mvd_pkg::TAU_STRONGEST_LEVEL)) begin
      tau = mvd_pkg::TAU_STRONGEST_LEVEL;
    end else begin
      tau = q.lp[2:0];
    end
    if (q.dtau > 16'(mvd_pkg::DRIFT_TAU_MAX)) begin
      dtau = mvd_pkg::DRIFT_TAU_MAX;
    end else begin
      dtau = q.dtau[3:0];
    end

    // Everything below moves only once per sensor sample.
    if (sample_tick) begin
      samp[mvd_pkg::AXIS_X_BIT] = field_x;
      samp[mvd_pkg::AXIS_Y_BIT] = field_y;
      samp[mvd_pkg::AXIS_Z_BIT] = field_z;
      for (int i = 0; i < mvd_pkg::AXIS_COUNT; i++) begin
        // Keep a three-deep window of unprocessed readings.
        next_q.hist[i] = q.raw[i];
        next_q.raw[i] = samp[i];
        med = mvd_med3(samp[i], q.raw[i], q.hist[i]);
        // Sensing path median can be bypassed.
        sense_val = q.smed[0] ? samp[i] : med;
        // Compensation (drift) path median can be bypassed.
        comp_val[i] = q.cmed[0] ? samp[i] : med;
        // Tau filter: level 0 passes the sample straight through.
        diff = mvd_sdiff(sense_val, q.filt[i]);
        step = diff >>> tau;
        acc = $signed({q.filt[i][15], q.filt[i]}) + step;
        next_q.filt[i] = acc[15:0];
        // Per-axis difference; zero before a baseline or for a disabled axis.
        if (q.base_valid && !q.dis[i]) begin
          next_q.dev[i] = mvd_absdiff(q.base[i], acc[15:0]);
        end else begin
          next_q.dev[i] = '0;
        end
        sum = sum + {2'b00, next_q.dev[i]};
      end
      // Saturate the sum so a large disturbance never wraps to a small value.
      if (|sum[17:16]) begin
        total = 16'hffff;
      end else begin
        total = sum[15:0];
      end
      // Rate of change filter: publish when the halved total moves by at least half of delta, or when the sum saturates.
      if (q.delta == '0 || mvd_absdiff({1'b0, total[15:1]}, {1'b0, q.total[15:1]}) >=
          {1'b0, q.delta[15:1]} || total == 16'hffff || q.delta == 16'h0001 &&
          total != q.total) begin
        next_q.total = total;
      end

      // Threshold and off point compare over the full unsigned range.
      above = next_q.total > q.thr;
      // When hysteresis exceeds threshold the off point is below zero and is never reached.
      below = (q.hys <= q.thr) && (next_q.total < (q.thr - q.hys));

      // Debounce and hysteresis decision.
      if (!q.state) begin
        next_q.off_cnt = '0;
        if (above) begin
          if (on_lim == '0 || q.on_cnt + 8'h01 >= on_lim) begin
            next_q.state = 1'b1;
            next_q.on_cnt = '0;
          end else begin
            next_q.on_cnt = q.on_cnt + 8'h01;
          end
        end else begin
          next_q.on_cnt = '0;
        end
      end else begin
        next_q.on_cnt = '0;
        if (below) begin
          if (off_lim == '0 || q.off_cnt + 8'h01 >= off_lim) begin
            next_q.state = 1'b0;
            next_q.off_cnt = '0;
          end else begin
            next_q.off_cnt = q.off_cnt + 8'h01;
          end
        end else begin
          next_q.off_cnt = '0;
        end
      end

      // Drift tracking: zero drift time turns it off.
      if (q.dtime != '0 && q.base_valid && next_q.total < q.dthr) begin
        drift_next = q.drift_cnt + 16'h0001;
        if (drift_next >= q.dtime) begin
          next_q.drift_cnt = '0;
          for (int i = 0; i < mvd_pkg::AXIS_COUNT; i++) begin
            diff = mvd_sdiff(comp_val[i], q.base[i]);
            step = diff >>> dtau;
            // A minimum step of one keeps the baseline from stalling short of ambient.
            if (step == 0 && diff > 0) begin
              step = 17'sd1;
            end else if (step == 0 && diff < 0) begin
              step = -17'sd1;
            end
            acc = $signed({q.base[i][15], q.base[i]}) + step;
            next_q.base[i] = acc[15:0];
          end
        end else begin
          next_q.drift_cnt = drift_next;
        end
      end else begin
        // A disturbance restarts the quiet interval.
        next_q.drift_cnt = '0;
      end
    end

    // Result word carries the detection state in its least significant bit.
    next_q.result = {next_q.total[15:1], next_q.state};

    // Host writes; read-only and unknown addresses flag an error and store nothing.
    if (reg_wr) begin
      case (reg_addr)
        mvd_pkg::ADDR_BASELINE_CAPTURE: begin
          if (reg_wdata == mvd_pkg::CAPTURE_COMMAND) begin
            // Capture uses the newest unprocessed readings and restarts drift timing.
            next_q.base = sample_tick ? next_q.raw : q.raw;
            next_q.base_valid = 1'b1;
            next_q.drift_cnt = '0;
            // Command completes at once, so the register reads back zero.
            next_q.cap = '0;
          end else begin
            next_q.cap = reg_wdata;
          end
        end
        mvd_pkg::ADDR_AXIS_DISABLE_MASK: begin
          next_q.dis = reg_wdata;
        end
        mvd_pkg::ADDR_COMP_MEDIAN_BYPASS: begin
          next_q.cmed = reg_wdata;
        end
        mvd_pkg::ADDR_SENSE_MEDIAN_BYPASS: begin
          next_q.smed = reg_wdata;
        end
        mvd_pkg::ADDR_LOWPASS_STRENGTH: begin
          next_q.lp = reg_wdata;
        end
        mvd_pkg::ADDR_ON_DEBOUNCE_COUNT: begin
          next_q.onc = reg_wdata;
        end
        mvd_pkg::ADDR_OFF_DEBOUNCE_COUNT: begin
          next_q.offc = reg_wdata;
        end
        mvd_pkg::ADDR_CHANGE_RATE_FILTER: begin
          next_q.delta = reg_wdata;
        end
        mvd_pkg::ADDR_DETECT_THRESHOLD: begin
          next_q.thr = reg_wdata;
        end
        mvd_pkg::ADDR_DETECT_HYSTERESIS: begin
          next_q.hys = reg_wdata;
        end
        mvd_pkg::ADDR_DRIFT_TIME: begin
          next_q.dtime = reg_wdata;
        end
        mvd_pkg::ADDR_DRIFT_THRESHOLD: begin
          next_q.dthr = reg_wdata;
        end
        mvd_pkg::ADDR_DRIFT_TAU: begin
          next_q.dtau = reg_wdata;
        end
        default: begin
          next_q.addr_err = 1'b1;
        end
      endcase
    end

    // Host reads return values held before this cycle.
    if (reg_rd) begin
      next_q.rd_valid = 1'b1;
      case (reg_addr)
        mvd_pkg::ADDR_BASELINE_CAPTURE: next_q.rd_data = q.cap;
        mvd_pkg::ADDR_AXIS_DISABLE_MASK: next_q.rd_data = q.dis;
        mvd_pkg::ADDR_COMP_MEDIAN_BYPASS: next_q.rd_data = q.cmed;
        mvd_pkg::ADDR_SENSE_MEDIAN_BYPASS: next_q.rd_data = q.smed;
        mvd_pkg::ADDR_LOWPASS_STRENGTH: next_q.rd_data = q.lp;
        mvd_pkg::ADDR_ON_DEBOUNCE_COUNT: next_q.rd_data = q.onc;
        mvd_pkg::ADDR_OFF_DEBOUNCE_COUNT: next_q.rd_data = q.offc;
        mvd_pkg::ADDR_CHANGE_RATE_FILTER: next_q.rd_data = q.delta;
        mvd_pkg::ADDR_DETECT_THRESHOLD: next_q.rd_data = q.thr;
        mvd_pkg::ADDR_DETECT_HYSTERESIS: next_q.rd_data = q.hys;
        mvd_pkg::ADDR_DRIFT_TIME: next_q.rd_data = q.dtime;
        mvd_pkg::ADDR_DRIFT_THRESHOLD: next_q.rd_data = q.dthr;
        mvd_pkg::ADDR_DRIFT_TAU: next_q.rd_data = q.dtau;
        mvd_pkg::ADDR_DEVIATION_TOTAL: next_q.rd_data = q.total;
        mvd_pkg::ADDR_DEVIATION_X: next_q.rd_data = q.dev[mvd_pkg::AXIS_X_BIT];
        mvd_pkg::ADDR_DEVIATION_Y: next_q.rd_data = q.dev[mvd_pkg::AXIS_Y_BIT];
        mvd_pkg::ADDR_DEVIATION_Z: next_q.rd_data = q.dev[mvd_pkg::AXIS_Z_BIT];
        mvd_pkg::ADDR_AMBIENT_X: next_q.rd_data = q.base[mvd_pkg::AXIS_X_BIT];
        mvd_pkg::ADDR_AMBIENT_Y: next_q.rd_data = q.base[mvd_pkg::AXIS_Y_BIT];
        mvd_pkg::ADDR_AMBIENT_Z: next_q.rd_data = q.base[mvd_pkg::AXIS_Z_BIT];
        mvd_pkg::ADDR_RAW_FIELD_X: next_q.rd_data = q.raw[mvd_pkg::AXIS_X_BIT];
        mvd_pkg::ADDR_RAW_FIELD_Y: next_q.rd_data = q.raw[mvd_pkg::AXIS_Y_BIT];
        mvd_pkg::ADDR_RAW_FIELD_Z: next_q.rd_data = q.raw[mvd_pkg::AXIS_Z_BIT];
        default: begin
          next_q.rd_data = '0;
          next_q.addr_err = 1'b1;
        end
      endcase
    end
  end

  // State register; reset loads factory defaults.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.thr <= mvd_pkg::RESET_DETECT_THRESHOLD;
      q.hys <= mvd_pkg::RESET_DETECT_HYSTERESIS;
      q.dis <= mvd_pkg::RESET_ZERO;
      q.onc <= mvd_pkg::RESET_ZERO;
      q.offc <= mvd_pkg::RESET_ZERO;
    end else begin
      q <= next_q;
    end
  end

endmodule

// ===== dv/mvd_detector_props.sv
// Checker of the register handshake, capture and detection output relations.
`timescale 1ns/1ns

module mvd_detector_props (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Sample strobe.
  input wire logic sample_tick,
  // Register access.
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_addr_err,
  // Detection results.
  input wire logic detect_state,
  input wire logic [15:0] detect_result,
  input wire logic baseline_valid
);
  // All relations live in the one clock domain.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read got no answer");
  chk_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without a read");
  chk_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved between reads");
  chk_ro_refused: assert property (reg_wr && reg_addr >= mvd_pkg::ADDR_DEVIATION_TOTAL
    && reg_addr <= mvd_pkg::ADDR_RAW_FIELD_Z |=> reg_addr_err)
    else $error("write to read-only place not refused");
  chk_capture_sets: assert property (reg_wr && reg_addr == mvd_pkg::ADDR_BASELINE_CAPTURE
    && reg_wdata == mvd_pkg::CAPTURE_COMMAND |=> baseline_valid)
    else $error("capture did not mark a baseline");
  chk_valid_sticky: assert property (baseline_valid |=> baseline_valid)
    else $error("baseline mark dropped");
  chk_no_base_quiet: assert property (!baseline_valid |-> detect_result == 16'h0000)
    else $error("result without a baseline");
  chk_lsb_state: assert property (detect_result[0] == detect_state)
    else $error("result bit differs from state");
  chk_state_on_tick: assert property ($changed(detect_state) |-> $past(sample_tick))
    else $error("state moved without a sample");
endmodule

bind mvd_detector mvd_detector_props mvd_detector_props_i (
  .mclk(mclk),
  .rst_n(rst_n),
  .sample_tick(sample_tick),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_wdata(reg_wdata),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .reg_addr_err(reg_addr_err),
  .detect_state(detect_state),
  .detect_result(detect_result),
  .baseline_valid(baseline_valid)
);

// ===== dv/mvd_sensor_model.sv
// Behavioural three-axis sensing element that delivers one sample per request.
`timescale 1ns/1ns

module mvd_sensor_model (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Request and the field values to deliver.
  input wire logic req,
  input wire logic signed [15:0] vx,
  input wire logic signed [15:0] vy,
  input wire logic signed [15:0] vz,
  // Sample stream towards the detector.
  output logic sample_tick,
  output logic signed [15:0] field_x,
  output logic signed [15:0] field_y,
  output logic signed [15:0] field_z
);
  // Between ticks the lines toggle, so a detector leaning on stale data is caught.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sample_tick <= 1'b0;
      field_x <= 16'h0000;
      field_y <= 16'h0000;
      field_z <= 16'h0000;
    end else if (req) begin
      sample_tick <= 1'b1;
      field_x <= vx;
      field_y <= vy;
      field_z <= vz;
    end else begin
      sample_tick <= 1'b0;
      field_x <= ~field_x;
      field_y <= ~field_y;
      field_z <= ~field_z;
    end
  end
endmodule

// ===== dv/mvd_detector_tb.sv
// Self-checking bench for the magnetic vehicle detector.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end

module mvd_detector_tb;
  logic mclk, rst_n, req, sample_tick;
  logic signed [15:0] vx, vy, vz, field_x, field_y, field_z;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, detect_result, a;
  logic reg_wr, reg_rd, reg_rvalid, reg_addr_err, detect_state, baseline_valid;
  int fails, checks_done, cyc, i;
  // Offsets from the baseline on x, with the expected state after each sample.
  int dx[14] = '{200, 120, 119, 150, 151, 0, 0, 200, 200, 200, 0, 200, 0, 0};
  logic [13:0] ds = 14'b01111000110011;

  mvd_sensor_model mvd_sensor_model_i (.mclk(mclk), .rst_n(rst_n), .req(req), .vx(vx),
    .vy(vy), .vz(vz), .sample_tick(sample_tick), .field_x(field_x), .field_y(field_y),
    .field_z(field_z));
  mvd_detector mvd_detector_i (.mclk(mclk), .rst_n(rst_n), .sample_tick(sample_tick),
    .field_x(field_x), .field_y(field_y), .field_z(field_z), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_addr_err(reg_addr_err), .detect_state(detect_state),
    .detect_result(detect_result), .baseline_valid(baseline_valid));

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // One write strobe; the write lands at the edge that samples it.
  task automatic wr(input logic [15:0] ad, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // One read strobe; answer and error pulse are looked at in their single cycle.
  task automatic rd(input logic [15:0] ad, input logic [15:0] e, input logic err);
    @(posedge mclk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, reg_rvalid)
    `CHK("addr_err", err, reg_addr_err)
    `CHK($sformatf("reg %h", ad), e, reg_rdata)
  endtask

  // Reads three per-axis registers that sit at consecutive offsets.
  task automatic trio(input logic [15:0] b, input int x, input int y, input int z);
    rd(b, 16'(x), 1'b0);
    rd(b + 16'h0001, 16'(y), 1'b0);
    rd(b + 16'h0002, 16'(z), 1'b0);
  endtask

  // Asks the sensor for one sample and waits until the detector has taken it.
  task automatic smp(input int x, input int y, input int z);
    @(posedge mclk);
    req <= 1'b1;
    vx <= 16'(x);
    vy <= 16'(y);
    vz <= 16'(z);
    @(posedge mclk);
    req <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  // Checks deviations, their total and the packed result word.
  task automatic dev(input int ex, input int ey, input int ez, input logic st);
    logic [15:0] t;
    t = 16'(ex + ey + ez);
    trio(mvd_pkg::ADDR_DEVIATION_X, ex, ey, ez);
    rd(mvd_pkg::ADDR_DEVIATION_TOTAL, t, 1'b0);
    `CHK("detect_result", {t[15:1], st}, detect_result)
    `CHK("detect_state", st, detect_state)
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // A hang is cut short well past the expected run length.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    rst_n = 1'b0;
    req = 1'b0;
    vx = 16'h0000;
    vy = 16'h0000;
    vz = 16'h0000;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fails = 0;
    checks_done = 0;
    cyc = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    // Reset values of the settings; the hole in the map must be refused.
    for (a = 16'h1195; a <= 16'h11a2; a++) begin
      rd(a, a == mvd_pkg::ADDR_DETECT_THRESHOLD ? mvd_pkg::RESET_DETECT_THRESHOLD :
        a == mvd_pkg::ADDR_DETECT_HYSTERESIS ? mvd_pkg::RESET_DETECT_HYSTERESIS :
        16'h0000, a == 16'h119c);
    end
    `CHK("baseline_valid", 1'b0, baseline_valid)
    // Full 16-bit range of threshold and hysteresis, then back to defaults.
    for (i = 0; i < 2; i++) begin
      wr(mvd_pkg::ADDR_DETECT_THRESHOLD + 16'(i), 16'hffff);
      rd(mvd_pkg::ADDR_DETECT_THRESHOLD + 16'(i), 16'hffff, 1'b0);
    end
    wr(mvd_pkg::ADDR_DETECT_THRESHOLD, mvd_pkg::RESET_DETECT_THRESHOLD);
    wr(mvd_pkg::ADDR_DETECT_HYSTERESIS, mvd_pkg::RESET_DETECT_HYSTERESIS);
    // Capture a baseline and see it, the raw values and the refused overwrite.
    wr(mvd_pkg::ADDR_SENSE_MEDIAN_BYPASS, 16'h0001);
    smp(100, 200, -50);
    trio(mvd_pkg::ADDR_RAW_FIELD_X, 100, 200, -50);
    wr(mvd_pkg::ADDR_BASELINE_CAPTURE, mvd_pkg::CAPTURE_COMMAND);
    trio(mvd_pkg::ADDR_AMBIENT_X, 100, 200, -50);
    rd(mvd_pkg::ADDR_BASELINE_CAPTURE, 16'h0000, 1'b0);
    `CHK("baseline_valid", 1'b1, baseline_valid)
    wr(mvd_pkg::ADDR_AMBIENT_X, 16'h1234);
    // The refusal pulse stands only in the cycle after the write edge.
    #1;
    `CHK("wr_err", 1'b1, reg_addr_err)
    rd(mvd_pkg::ADDR_AMBIENT_X, 16'h0064, 1'b0);
    // Deviation, then each axis masked in turn.
    smp(130, 180, -90);
    dev(30, 20, 40, 1'b0);
    for (i = 0; i < 3; i++) begin
      wr(mvd_pkg::ADDR_AXIS_DISABLE_MASK, 16'(1 << i));
      smp(130, 180, -90);
      dev(i == 0 ? 0 : 30, i == 1 ? 0 : 20, i == 2 ? 0 : 40, 1'b0);
    end
    wr(mvd_pkg::ADDR_AXIS_DISABLE_MASK, 16'h0000);
    // Hysteresis edges first, then on and off debounce of three and two samples.
    for (i = 0; i < 14; i++) begin
      if (i == 5) begin
        wr(mvd_pkg::ADDR_ON_DEBOUNCE_COUNT, 16'h0003);
        wr(mvd_pkg::ADDR_OFF_DEBOUNCE_COUNT, 16'h0002);
      end
      smp(100 + dx[i], 200, -50);
      dev(dx[i], 0, 0, ds[i]);
    end
    // With the median back on, a lone spike is swallowed.
    wr(mvd_pkg::ADDR_SENSE_MEDIAN_BYPASS, 16'h0000);
    smp(400, 200, -50);
    rd(mvd_pkg::ADDR_DEVIATION_X, 16'h0000, 1'b0);
    wr(mvd_pkg::ADDR_SENSE_MEDIAN_BYPASS, 16'h0001);
    // Every tau level: one step of 640 is cut by two to the power of the level.
    for (i = 0; i <= 6; i++) begin
      wr(mvd_pkg::ADDR_LOWPASS_STRENGTH, 16'h0000);
      smp(100, 200, -50);
      wr(mvd_pkg::ADDR_LOWPASS_STRENGTH, 16'(i));
      smp(740, 200, -50);
      rd(mvd_pkg::ADDR_DEVIATION_X, 16'(640 >> i), 1'b0);
    end
    // Drift with the shortest time and no shift pulls the baseline fully.
    wr(mvd_pkg::ADDR_LOWPASS_STRENGTH, 16'h0000);
    wr(mvd_pkg::ADDR_COMP_MEDIAN_BYPASS, 16'h0001);
    wr(mvd_pkg::ADDR_DRIFT_THRESHOLD, 16'hffff);
    wr(mvd_pkg::ADDR_DRIFT_TIME, 16'h0001);
    smp(120, 200, -50);
    trio(mvd_pkg::ADDR_AMBIENT_X, 120, 200, -50);
    test_done();
  end
endmodule
